// ===== src/modem_ctrl.sv
// rate decode, channel gating, aux transport, handshake and register slave of the modem
// Function
// - select low gives three channels, open gives one
// - single mode ignores lanes 2-3, aux 3; tri-states
// - three-channel rate table applies to all channels
// - single-channel rate table applies to channel one
// - low bits 110 select asynchronous operation
// - top rate bit selects reach; code 0 and single-mode code 5 are always short
// - aux mode low transports data, high handshakes
// - aux sampled at crystal/1536 short, /3072 long
// - handshake mode drives DSR low when powered
// - DTR high forces carrier detect high in handshake mode
// - CTS follows RTS in handshake mode
// - carrier detect low on lock; loss raises both
// - three-channel async sampling at /108 or /216
// - single-channel async sampling at /36 or /72
// - reset pin or diag code 001 stops logic
// - link traffic is DC-free 3B4B coded transparently
// - receive data filtered again before output
// - receive phase aligned to peer, delay compensated
// - select low drives bit clock, captures rising
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module modem_ctrl (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    chan_mode_sel,
  input  wire logic [3:0]              rate_code,
  input  wire logic                    aux_line_mode,
  input  wire logic [2:0]              aux_in,
  input  wire logic [2:0]              tx_serial_in,
  input  wire logic                    power_on_reset_n,
  input  wire logic [2:0]              diag_mode_code,
  input  wire logic                    clock_source_select,
  input  wire logic                    tx_bit_clock_in,
  input  wire logic                    link_locked,
  input  wire logic [2:0]              link_rx_data,
  input  wire logic [2:0]              link_rx_aux,
  output var  modem_ctrl_pkg::tri3_s    rx_serial_out,
  output var  modem_ctrl_pkg::tri3_s    aux_out,
  output logic                         carrier_detect_n,
  output logic                         tx_bit_clock,
  output logic                         tx_bit_clock_oe,
  output var  modem_ctrl_pkg::link_tx_s link_tx,
  output logic                         led_drive_en,
  output logic                         tx_enable
);
  import modem_ctrl_pkg::*;

  typedef struct packed {
    logic             hold;
    logic             ctrl_hold;
    logic             ctrl_txen;
    rate_cfg_s        cfg;
    logic             single;
    logic             hs_mode;
    hs_e              hs;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [16:0]      acc;
    logic             txclk;
    logic             txclk_oe;
    logic             clk_prev;
    logic [2:0]       txd;
    logic [2:0]       aux_tx;
    logic [2:0][1:0]  rx_hist;
    tri3_s            rx;
    tri3_s            aux;
    logic [2:0]       aux_cand;
    logic [2:0][1:0]  aux_cnt;
    logic [2:0]       aux_lvl;
    logic             dcd_n;
    logic             led_en;
    logic             tx_en;
  } ctl_state_s;

  ctl_state_s  st;
  ctl_state_s  next_st;
  pins_s       pin;
  logic        aux_tick;
  logic        async_tick;
  logic [11:0] aux_period;
  logic [11:0] async_period;

  // every pin crosses in through three flops
  pin_sync #(
    .WIDTH   (18),
    .RST_VAL (PINS_RESET)
  ) u_pins (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   ({chan_mode_sel, aux_line_mode, rate_code, aux_in, tx_serial_in,
             power_on_reset_n, diag_mode_code, clock_source_select, tx_bit_clock_in}),
    .level (pin)
  );

  // sample clocks for aux lines and async data
  assign aux_period = st.cfg.short_reach ? AUX_DIV_SHORT : AUX_DIV_LONG;
  assign async_period = st.single ?
                        (st.cfg.short_reach ? ASYNC1_DIV_SHORT : ASYNC1_DIV_LONG) :
                        (st.cfg.short_reach ? ASYNC3_DIV_SHORT : ASYNC3_DIV_LONG);

  tick_div #(
    .W (12)
  ) u_aux_div (
    .clk    (clk),
    .rst_b  (rst_b),
    .clear  (st.hold),
    .period (aux_period),
    .tick   (aux_tick)
  );

  tick_div #(
    .W (12)
  ) u_async_div (
    .clk    (clk),
    .rst_b  (rst_b),
    .clear  (st.hold | ~st.cfg.async),
    .period (async_period),
    .tick   (async_tick)
  );

  always_comb begin
    logic [17:0] sum;
    logic        sel_clk;
    logic        clk_rise;
    logic [2:0]  txd_in;
    logic [31:0] rd;
    next_st = st;
    sum = '0;
    rd = '0;
    sel_clk = 1'b0;
    clk_rise = 1'b0;
    txd_in = '0;

    // mode pins; select pulls high when open
    next_st.single = pin.sel;
    next_st.hs_mode = pin.line_mode;
    next_st.cfg = decode_rate(pin.rate, pin.sel);
    next_st.hold = !pin.por_n || (pin.diag == DIAG_RESET) || st.ctrl_hold;
    next_st.led_en = !next_st.hold;
    next_st.tx_en = next_st.cfg.valid && st.ctrl_txen && !next_st.hold;

    // bit clock: phase accumulator keeps non-integer ratios such as 56k exact
    next_st.txclk_oe = !pin.clk_src;
    if (st.hold || !st.cfg.valid || st.cfg.async) begin
      next_st.acc = '0;
      next_st.txclk = 1'b0;
    end else begin
      sum = {1'b0, st.acc} + {5'h00, st.cfg.rate, 1'b0};
      if (sum >= {1'b0, XTAL_HHZ}) begin
        next_st.acc = 17'(sum - {1'b0, XTAL_HHZ});
        next_st.txclk = !st.txclk;
      end else begin
        next_st.acc = sum[16:0];
      end
    end

    // capture data on the rising edge of whichever clock is in use
    sel_clk = st.txclk_oe ? st.txclk : pin.txclk;
    next_st.clk_prev = sel_clk;
    clk_rise = sel_clk && !st.clk_prev;
    txd_in = {st.single | pin.txd[2], st.single | pin.txd[1], pin.txd[0]};
    if (st.hold) begin
      next_st.txd = 3'h7;
    end else if (st.cfg.async ? async_tick : clk_rise) begin
      next_st.txd = txd_in;
    end else if (st.single) begin
      next_st.txd[2:1] = 2'h3;                                 // no stale lane bits
    end

    // aux transport toward the link; 3B4B coding happens in the line coder
    if (st.hold) begin
      next_st.aux_tx = 3'h7;
    end else if (aux_tick) begin
      next_st.aux_tx = st.hs_mode ? 3'h7 : {st.single | pin.aux[2], pin.aux[1:0]};
    end

    // far-end aux filter: four agreeing samples, well inside the six guaranteed
    for (int i = 0; i < 3; i++) begin
      if (st.hold) begin
        next_st.aux_cnt[i] = 2'h0;
        next_st.aux_cand[i] = 1'b1;
        next_st.aux_lvl[i] = 1'b1;
      end else if (aux_tick) begin
        if (link_rx_aux[i] == st.aux_cand[i]) begin
          if (st.aux_cnt[i] < FILT_RUN) begin
            next_st.aux_cnt[i] = st.aux_cnt[i] + 2'h1;
          end else begin
            next_st.aux_lvl[i] = st.aux_cand[i];
          end
        end else begin
          next_st.aux_cand[i] = link_rx_aux[i];
          next_st.aux_cnt[i] = 2'h0;
        end
      end
      // receive data gets a 2-of-3 majority before the pin
      next_st.rx_hist[i] = {st.rx_hist[i][0], link_rx_data[i]};
      next_st.rx.val[i] = st.hold ? 1'b1 :
                          ((st.rx_hist[i][1] & st.rx_hist[i][0]) |
                           (st.rx_hist[i][1] & link_rx_data[i]) |
                           (st.rx_hist[i][0] & link_rx_data[i]));
    end
    next_st.rx.oe = {!st.single, !st.single, 1'b1};

    // handshake: lock comes from the phase-aligning link core
    unique case (st.hs)
      HS_IDLE: begin
        if (st.hs_mode && !st.hold) begin
          next_st.hs = HS_READY;
        end
      end
      HS_READY: begin
        if (!st.hs_mode || st.hold) begin
          next_st.hs = HS_IDLE;
        end else if (!pin.aux[0] && link_locked && !st.dcd_n) begin
          next_st.hs = HS_CLEAR;
        end
      end
      HS_CLEAR: begin
        if (!st.hs_mode || st.hold) begin
          next_st.hs = HS_IDLE;
        end else if (pin.aux[0] || !link_locked) begin
          next_st.hs = HS_READY;
        end
      end
    endcase
    next_st.dcd_n = !link_locked || st.hold || (st.hs_mode && pin.aux[1]);
    if (st.hs_mode) begin
      next_st.aux.val = {1'b1, next_st.hs == HS_IDLE, next_st.hs != HS_CLEAR};
    end else begin
      next_st.aux.val = st.aux_lvl;
    end
    next_st.aux.oe = {!st.single, 2'b11};

    // axi4-lite write: address and data in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.awaddr[7:2] == OFS_CTRL[7:2]) begin
        if (st.wstrb[0]) begin
          next_st.ctrl_hold = st.wdata[CTRL_HOLD_BIT];
          next_st.ctrl_txen = st.wdata[CTRL_TXEN_BIT];
        end
      end else if (st.awaddr[7:2] != OFS_STATUS[7:2] && st.awaddr[7:2] != OFS_AUX[7:2]) begin
        next_st.bresp = RESP_DECERR;
      end
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;

    // axi4-lite read, answered on the same edge that takes the address
    rd[CTRL_HOLD_BIT] = st.ctrl_hold;
    rd[CTRL_TXEN_BIT] = st.ctrl_txen;
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      if (s_axi_araddr[7:2] == OFS_STATUS[7:2]) begin
        rd = '0;
        rd[ST_RATE_LSB +: 4] = pin.rate;
        rd[ST_SINGLE] = st.single;
        rd[ST_ASYNC] = st.cfg.async;
        rd[ST_SHORT] = st.cfg.short_reach;
        rd[ST_VALID] = st.cfg.valid;
        rd[ST_LOCKED] = link_locked;
        rd[ST_HOLD] = st.hold;
        rd[ST_HS_LSB +: 3] = st.hs;
      end else if (s_axi_araddr[7:2] == OFS_AUX[7:2]) begin
        rd = '0;
        rd[AUX_IN_LSB +: 3] = pin.aux;
        rd[AUX_RX_LSB +: 3] = st.aux_lvl;
      end else if (s_axi_araddr[7:2] != OFS_CTRL[7:2]) begin
        rd = '0;
        next_st.rresp = RESP_DECERR;
      end
      next_st.rdata = rd;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.hold <= 1'b1;
      st.ctrl_txen <= CTRL_RESET[CTRL_TXEN_BIT];
      st.ctrl_hold <= CTRL_RESET[CTRL_HOLD_BIT];
      st.single <= 1'b1;
      st.hs <= HS_IDLE;
      st.txd <= 3'h7;
      st.aux_tx <= 3'h7;
      st.aux_cand <= 3'h7;
      st.aux_lvl <= 3'h7;
      st.rx <= '{val: 3'h7, oe: 3'h1};
      st.aux <= '{val: 3'h7, oe: 3'h3};
      st.dcd_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign rx_serial_out = st.rx;
  assign aux_out = st.aux;
  assign carrier_detect_n = st.dcd_n;
  assign tx_bit_clock = st.txclk;
  assign tx_bit_clock_oe = st.txclk_oe;
  assign link_tx = '{data: st.txd, aux: st.aux_tx};
  assign led_drive_en = st.led_en;
  assign tx_enable = st.tx_en;

  // helper: cycles since the last aux tick at an unchanged period
  logic [12:0] aux_gap;
  logic        aux_seen;
  logic [11:0] aux_per_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_gap <= '0;
      aux_seen <= 1'b0;
      aux_per_q <= '0;
    end else begin
      aux_per_q <= aux_period;
      aux_gap <= aux_tick ? 13'h0000 : aux_gap + 13'h0001;
      aux_seen <= (aux_tick || aux_seen) && !st.hold && (aux_per_q == aux_period);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence rts_raised;
    st.hs_mode && !st.hold && pin.aux[0];
  endsequence
  sequence cts_high_two;
    aux_out.val[0] [*2];
  endsequence

  single_tristate_a: assert property (st.single |=> (rx_serial_out.oe == 3'h1) && !aux_out.oe[2])
    else $error("single mode left lanes 2-3 driven");
  async_decode_a: assert property (pin.rate[2:0] == ASYNC_LOW3 |=> st.cfg.async)
    else $error("async code not decoded");
  reach_bit_a: assert property (st.cfg.valid && !st.single && !st.cfg.async |-> st.cfg.short_reach == $past(pin.rate[3]))
    else $error("reach not taken from top rate bit");
  aux_period_a: assert property (aux_tick && aux_seen |-> aux_gap == 13'(aux_per_q) - 13'h0001)
    else $error("aux sample spacing wrong");
  dsr_active_a: assert property (st.hs_mode && !st.hold |=> !aux_out.val[1])
    else $error("dsr not asserted in handshake mode");
  dtr_forces_dcd_a: assert property (st.hs_mode && pin.aux[1] |=> carrier_detect_n)
    else $error("carrier detect low with dtr inactive");
  cts_release_a: assert property (rts_raised ##1 rts_raised |-> cts_high_two)
    else $error("cts stayed low after rts released");
  lost_sync_a: assert property (st.hs_mode && !link_locked |=> carrier_detect_n && aux_out.val[0])
    else $error("loss of lock left dcd or cts active");
  reset_hold_a: assert property (pin.diag == DIAG_RESET |=> !led_drive_en && !tx_enable)
    else $error("diag reset did not stop led drive");
  txclk_dir_a: assert property (!pin.clk_src |=> tx_bit_clock_oe)
    else $error("bit clock not driven with internal source");
  invalid_rate_a: assert property (!st.cfg.valid |-> !tx_enable)
    else $error("transmit enabled on unavailable rate");

endmodule
`default_nettype wire

// ===== src/modem_ctrl_pkg.sv
// shared constants, types and rate decode for the fiber modem control block
package modem_ctrl_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_AUX    = 8'h08;

  // ctrl fields and reset value
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam int unsigned CTRL_TXEN_BIT = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h2;

  // status fields
  localparam int unsigned ST_RATE_LSB  = 0;
  localparam int unsigned ST_SINGLE    = 4;
  localparam int unsigned ST_ASYNC     = 5;
  localparam int unsigned ST_SHORT     = 6;
  localparam int unsigned ST_VALID     = 7;
  localparam int unsigned ST_LOCKED    = 8;
  localparam int unsigned ST_HOLD      = 9;
  localparam int unsigned ST_HS_LSB    = 10;

  // aux register fields
  localparam int unsigned AUX_IN_LSB   = 0;
  localparam int unsigned AUX_RX_LSB   = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // sample dividers in crystal periods
  localparam logic [11:0] AUX_DIV_SHORT   = 12'h600;
  localparam logic [11:0] AUX_DIV_LONG    = 12'hC00;
  localparam logic [11:0] ASYNC3_DIV_SHORT = 12'h06C;
  localparam logic [11:0] ASYNC3_DIV_LONG  = 12'h0D8;
  localparam logic [11:0] ASYNC1_DIV_SHORT = 12'h024;
  localparam logic [11:0] ASYNC1_DIV_LONG  = 12'h048;

  // crystal and bit rates in units of 100 Hz
  localparam logic [16:0] XTAL_HHZ = 17'h16800;
  localparam logic [11:0] R_2K4    = 12'h018;
  localparam logic [11:0] R_9K6    = 12'h060;
  localparam logic [11:0] R_19K2   = 12'h0C0;
  localparam logic [11:0] R_38K4   = 12'h180;
  localparam logic [11:0] R_48K    = 12'h1E0;
  localparam logic [11:0] R_56K    = 12'h230;
  localparam logic [11:0] R_64K    = 12'h280;
  localparam logic [11:0] R_192K   = 12'h780;
  localparam logic [11:0] R_256K   = 12'hA00;

  localparam logic [2:0] DIAG_RESET = 3'h1;
  localparam logic [2:0] ASYNC_LOW3 = 3'h6;
  localparam logic [1:0] FILT_RUN   = 2'h2;

  // synchronised pin bundle, msb first
  typedef struct packed {
    logic       sel;
    logic       line_mode;
    logic [3:0] rate;
    logic [2:0] aux;
    logic [2:0] txd;
    logic       por_n;
    logic [2:0] diag;
    logic       clk_src;
    logic       txclk;
  } pins_s;
  // idle levels: single mode, handshake lines inactive, out of reset
  localparam logic [17:0] PINS_RESET = 18'h20FE0;

  typedef struct packed {
    logic [2:0] val;
    logic [2:0] oe;
  } tri3_s;

  typedef struct packed {
    logic [2:0] data;
    logic [2:0] aux;
  } link_tx_s;

  typedef struct packed {
    logic        valid;
    logic        async;
    logic        short_reach;
    logic [11:0] rate;
  } rate_cfg_s;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_READY = 3'b010,
    HS_CLEAR = 3'b100
  } hs_e;

  // low three bits pick the rate, top bit the reach; codes 0 and 5 also take the rate from the top bit and may force short reach
  function automatic rate_cfg_s decode_rate(input logic [3:0] code, input logic single);
    rate_cfg_s c;
    c = '0;
    c.valid = 1'b1;
    c.short_reach = code[3];
    unique case (code[2:0])
      3'h0: begin
        c.rate = code[3] ? R_2K4 : R_256K;
        c.valid = code[3] | single;
        c.short_reach = 1'b1;
      end
      3'h1: c.rate = R_9K6;
      3'h2: c.rate = R_19K2;
      3'h3: c.rate = R_38K4;
      3'h4: begin
        c.rate = R_48K;
        c.valid = code[3] | single;
      end
      3'h5: begin
        c.rate = code[3] ? R_56K : R_192K;
        c.valid = code[3] | single;
        c.short_reach = code[3] | single;
      end
      3'h6: c.async = 1'b1;
      3'h7: begin
        c.rate = R_64K;
        c.valid = code[3] | single;
      end
    endcase
    return c;
  endfunction

endpackage

// ===== src/pin_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned          WIDTH   = 1,
  parameter logic [WIDTH-1:0]     RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] level;
  } sync_state_s;

  sync_state_s st;
  sync_state_s next_st;

  // ff1 feeds only ff2; disagreeing bits keep the old level
  always_comb begin
    next_st = st;
    next_st.ff1 = pin;
    next_st.ff2 = st.ff1;
    next_st.ff3 = st.ff2;
    next_st.level = (st.ff2 & ~(st.ff2 ^ st.ff3)) | (st.level & (st.ff2 ^ st.ff3));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st.ff1 <= RST_VAL;
      st.ff2 <= RST_VAL;
      st.ff3 <= RST_VAL;
      st.level <= RST_VAL;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
endmodule
`default_nettype wire

// ===== src/tick_div.sv
// programmable divider giving one-cycle ticks every period clocks
`timescale 1ns/1ps
`default_nettype none
module tick_div #(
  parameter int unsigned W = 12
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         clear,
  input  wire logic [W-1:0] period,
  output logic              tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_state_s;

  div_state_s st;
  div_state_s next_st;

  // wraps on >= so a shrinking period never runs away
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (clear) begin
      next_st.cnt = '0;
    end else if (st.cnt >= period - W'(1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule
`default_nettype wire

// ===== tb/link_peer.sv
// far-end peer model: echoes coded traffic back and reports lock
`timescale 1ns/1ps
`default_nettype none
module link_peer (
  input  wire logic                     clk,
  input  wire logic                     lock_req,
  input  wire modem_ctrl_pkg::link_tx_s tx,
  output logic                          locked,
  output logic [2:0]                    rx_data,
  output logic [2:0]                    rx_aux
);
  import modem_ctrl_pkg::*;
  // one clk of line delay; the user path never sees the coding
  always_ff @(posedge clk) begin
    locked  <= lock_req;
    rx_data <= tx.data;
    rx_aux  <= tx.aux;
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the modem control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import modem_ctrl_pkg::*;
  logic        clk, rst_b, awv, wv, bready, arv, rready, sel, mode, por_n, lock_req;
  logic        awr, wr, bv, arr, rv, dcd_n, locked, led, txen, tcl, tco;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [31:0] lf = 32'h4394E97C;
  logic [1:0]  br, rr;
  logic [3:0]  rate;
  logic [2:0]  aux, txd, diag, rxd, rxa;
  tri3_s       rxo, auxo;
  link_tx_s    ltx;
  int          n_mismatch = 0;
  int          n_checks = 0;
  modem_ctrl modem_ctrl_i (.clk, .rst_b, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .chan_mode_sel(sel),
    .rate_code(rate), .aux_line_mode(mode), .aux_in(aux), .tx_serial_in(txd),
    .power_on_reset_n(por_n), .diag_mode_code(diag), .clock_source_select(1'b0),
    .tx_bit_clock_in(1'b0), .link_locked(locked), .link_rx_data(rxd), .link_rx_aux(rxa),
    .rx_serial_out(rxo), .aux_out(auxo), .carrier_detect_n(dcd_n), .tx_bit_clock(tcl),
    .tx_bit_clock_oe(tco), .link_tx(ltx), .led_drive_en(led), .tx_enable(txen));
  link_peer link_peer_i (.clk, .lock_req, .tx(ltx), .locked, .rx_data(rxd), .rx_aux(rxa));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // random serial lanes from the lfsr
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk) begin
    lf <= lfsr(lf);
    txd <= lf[2:0];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // write: both channels offered together, released as each is taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    chk(br, r);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  // read and compare masked data plus response
  task automatic axr(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    chk(rd & m, e);
    chk(rr, r);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // hang guard, well beyond the longest aux wait
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    bit v, sh, as;
    {awv, wv, bready, arv, rready, awa, ara, wd, lock_req, mode} = '0;
    {sel, por_n, rst_b, diag, aux, rate} = {3'b110, 3'h7, 3'h7, 4'h9};
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    axr(OFS_CTRL, 32'h3, {30'h0, CTRL_RESET}, RESP_OKAY);
    axr(8'h0C, '1, '0, RESP_DECERR);
    axw(8'h0C, 32'h1, RESP_DECERR);
    // every code in both channel modes against the rate tables
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 16; c++) begin
        sel <= s[0];
        rate <= c[3:0];
        repeat (8) @(posedge clk);
        v = s == 1 || c >= 8 || c inside {1, 2, 3, 6};
        as = c % 8 == 6;
        sh = c >= 8 || (s == 1 && c inside {0, 5});
        axr(OFS_STATUS, v ? 32'hFF : 32'hBF, {v, sh, as, s[0], c[3:0]}, RESP_OKAY);
        if (!v) chk(txen, 1'b0);
        if (!v) chk({tcl, tco}, 2'h1);
        chk({rxo.oe, auxo.oe}, s ? 6'h0B : 6'h3F);
        if (s) chk(ltx.data[2:1], 2'h3);
        if (s) chk(rxo.val[2:1], 2'h3);
      end
    end
    // aux transport, short reach: four samples at 1536 clk spacing
    sel <= 1'b0;
    rate <= 4'h9;
    lock_req <= 1'b1;
    aux <= 3'h2;
    repeat (3000) @(posedge clk);
    chk(auxo.val == 3'h2, 1'b0);
    repeat (6500) @(posedge clk); // level held past six sample periods
    chk(auxo.val, 3'h2);
    // handshake: DTR high, then DTR low, RTS low, lock lost
    mode <= 1'b1;
    aux <= 3'h7;
    repeat (8) @(posedge clk);
    chk({dcd_n, auxo.val[1:0]}, 3'h5);
    aux <= 3'h5;
    repeat (8) @(posedge clk);
    chk({dcd_n, auxo.val[1:0]}, 3'h1);
    aux <= 3'h4; // rts lowered only once dcd was seen low
    repeat (8) @(posedge clk);
    chk({dcd_n, auxo.val[1:0]}, 3'h0);
    lock_req <= 1'b0;
    repeat (8) @(posedge clk);
    chk({dcd_n, auxo.val[0]}, 2'h3);
    // hold by diag code, reset pin and soft bit
    diag <= DIAG_RESET;
    repeat (8) @(posedge clk);
    chk(led, 1'b0);
    diag <= 3'h7;
    por_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(led, 1'b0);
    por_n <= 1'b1;
    axw(OFS_CTRL, 32'h3, RESP_OKAY);
    axr(OFS_CTRL, 32'h3, 32'h3, RESP_OKAY);
    chk(led, 1'b0);
    axw(OFS_CTRL, 32'h2, RESP_OKAY);
    repeat (8) @(posedge clk);
    chk(led, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
